// File: design/trw_pkg.sv
`default_nettype none
package trw_pkg;
   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int PTR_W = 10;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 6;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [5:0] OFF_CAPTURE_CONTROL = 6'h00;
   localparam logic [5:0] OFF_FLUSH_STATUS = 6'h04;
   localparam logic [5:0] OFF_WRITE_POINTER = 6'h08;
   localparam logic [5:0] OFF_TRIGGER_COUNT = 6'h0C;
   localparam logic [5:0] OFF_WRITE_DATA = 6'h10;
   localparam logic [5:0] OFF_IRQ_STATUS = 6'h14;
   localparam logic [5:0] OFF_IRQ_MASK = 6'h18;
   localparam logic [5:0] OFF_READ_POINTER = 6'h1C;
   localparam logic [5:0] OFF_READ_DATA = 6'h20;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CAPTURE_ENABLE_BIT = 0;
   localparam int FLUSH_HALTED_BIT = 1;
   localparam int FLUSH_FULL_BIT = 0;
   localparam int IRQ_W = 3;
   localparam int IRQ_WRAP_BIT = 0;
   localparam int IRQ_TRIG_DONE_BIT = 1;
   localparam int IRQ_HALTED_BIT = 2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [9:0] RST_POINTER = 10'h000;
   localparam logic [9:0] RST_TRIGGER_COUNT = 10'h000;
   localparam logic [2:0] RST_IRQ_MASK = 3'h0;
   localparam logic [31:0] RST_READ_DATA = 32'h00000000;

   // ----------------------------------------------------------------
   // Formatter states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TRW_RUN = 2'b00,
      TRW_DRAIN = 2'b01,
      TRW_HALT = 2'b10
   } trw_fmt_state_t;
endpackage
`default_nettype wire

// File: design/trw_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface trw_link_if (
   input wire logic ref_clk
);
   logic word_valid;
   logic [31:0] word_data;
   logic word_trigger;
   logic stop_req;
   logic halted;

   modport dev (
      input word_valid,
      input word_data,
      input word_trigger,
      input halted,
      output stop_req
   );

   modport fmt (
      output word_valid,
      output word_data,
      output word_trigger,
      output halted,
      input stop_req
   );
endinterface
`default_nettype wire

// File: design/trw_formatter.sv
`timescale 1ns/10ps
`default_nettype none
module trw_formatter (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic ce,
   trw_link_if.fmt link,
   input wire logic in_valid,
   input wire logic [31:0] in_data,
   input wire logic in_trigger,
   output logic in_ready
);
   trw_pkg::trw_fmt_state_t state_ff;
   logic hold_valid_ff;
   logic [31:0] hold_data_ff;
   logic hold_trig_ff;

   // ----------------------------------------------------------------
   // Stop sequencing
   // ----------------------------------------------------------------
   // drain then halt
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_ff <= trw_pkg::TRW_HALT;
      end else if (ce) begin
         unique case (state_ff)
            trw_pkg::TRW_RUN: begin
               if (link.stop_req) begin
                  state_ff <= trw_pkg::TRW_DRAIN;
               end
            end
            trw_pkg::TRW_DRAIN: begin
               state_ff <= trw_pkg::TRW_HALT;
            end
            trw_pkg::TRW_HALT: begin
               if (!link.stop_req) begin
                  state_ff <= trw_pkg::TRW_RUN;
               end
            end
            default: begin
               state_ff <= trw_pkg::TRW_HALT;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Word stage
   // ----------------------------------------------------------------
   // The word taken in the cycle the stop arrives is still shown during drain
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         hold_valid_ff <= 1'b0;
         hold_trig_ff <= 1'b0;
         hold_data_ff <= 32'h00000000;
      end else if (ce) begin
         hold_valid_ff <= (state_ff == trw_pkg::TRW_RUN) && in_valid;
         hold_trig_ff <= (state_ff == trw_pkg::TRW_RUN) && in_valid && in_trigger;
         if (state_ff == trw_pkg::TRW_RUN && in_valid) begin
            hold_data_ff <= in_data;
         end
      end
   end

   assign in_ready = (state_ff == trw_pkg::TRW_RUN) || (state_ff == trw_pkg::TRW_HALT);
   assign link.halted = (state_ff == trw_pkg::TRW_HALT);
   assign link.word_valid = hold_valid_ff;
   assign link.word_data = hold_data_ff;
   assign link.word_trigger = hold_trig_ff;
endmodule
`default_nettype wire

// File: design/trw_trace_dev.sv
// What this block does
// - Each valid formatter word stored, pointer advances
// - Pointer wrap to zero sets full
// - Software loads pointer while capture stopped
// - Pointer writes ignored during capture
// - Pointer read returns current location
// - Software keeps pointer 128-bit aligned
// - Pointer is ten low bits, rest reserved
// - Count exhausted stops formatter, blocks writes
// - Post-trigger words equal count plus one
// - Software picks count for before/after/about
// - Trigger count writes ignored during capture
// - Disable drains formatter then halts
// - Halted flag set, later input discarded
// - Write-data register stores word, increments pointer
//
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module trw_trace_dev #(
   parameter int PTR_W = trw_pkg::PTR_W
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic ce,
   trw_link_if.dev link,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq
);
   // ----------------------------------------------------------------
   // Storage and state
   // ----------------------------------------------------------------
   logic [31:0] mem [0:(1 << PTR_W) - 1];
   logic cap_en_ff;
   logic [PTR_W-1:0] wp_ff;
   logic [PTR_W-1:0] rp_ff;
   logic full_ff;
   logic [PTR_W-1:0] trg_ff;
   logic [PTR_W-1:0] cnt_ff;
   logic armed_ff;
   logic done_ff;
   logic halted_d_ff;
   logic ack_ff;
   logic [31:0] rdata_ff;
   logic [2:0] ist_ff;
   logic [2:0] imask_ff;

   logic capturing;
   logic wr;
   logic rd;
   logic hw_store;
   logic sw_store;
   logic store;
   logic [31:0] store_data;
   logic wrap;
   logic enable_rise;
   logic [2:0] irq_ev;
   logic [2:0] irq_clr;

   function automatic logic hit(input logic [5:0] addr, input logic [5:0] off);
      hit = (addr == off);
   endfunction

   function automatic logic [31:0] zext(input logic [PTR_W-1:0] v);
      zext = 32'h00000000;
      zext[PTR_W-1:0] = v;
   endfunction

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   // One wait cycle per access; a write lands on the edge after waitrequest drops
   assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
   assign wr = avs_write && ack_ff;
   assign rd = avs_read && ack_ff;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ack_ff <= 1'b0;
      end else if (ce) begin
         ack_ff <= (avs_read || avs_write) && !ack_ff;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rdata_ff <= trw_pkg::RST_READ_DATA;
      end else if (ce && avs_read && !ack_ff) begin
         rdata_ff <= 32'h00000000;
         if (hit(avs_address, trw_pkg::OFF_CAPTURE_CONTROL)) begin
            rdata_ff[trw_pkg::CAPTURE_ENABLE_BIT] <= cap_en_ff;
         end
         if (hit(avs_address, trw_pkg::OFF_FLUSH_STATUS)) begin
            rdata_ff[trw_pkg::FLUSH_HALTED_BIT] <= link.halted;
            rdata_ff[trw_pkg::FLUSH_FULL_BIT] <= full_ff;
         end
         if (hit(avs_address, trw_pkg::OFF_WRITE_POINTER)) begin
            rdata_ff <= zext(wp_ff);
         end
         if (hit(avs_address, trw_pkg::OFF_TRIGGER_COUNT)) begin
            rdata_ff <= zext(trg_ff);
         end
         if (hit(avs_address, trw_pkg::OFF_IRQ_STATUS)) begin
            rdata_ff[2:0] <= ist_ff;
         end
         if (hit(avs_address, trw_pkg::OFF_IRQ_MASK)) begin
            rdata_ff[2:0] <= imask_ff;
         end
         if (hit(avs_address, trw_pkg::OFF_READ_POINTER)) begin
            rdata_ff <= zext(rp_ff);
         end
         if (hit(avs_address, trw_pkg::OFF_READ_DATA)) begin
            rdata_ff <= mem[rp_ff];
         end
      end
   end
   assign avs_readdata = rdata_ff;

   // ----------------------------------------------------------------
   // Capture control
   // ----------------------------------------------------------------
   assign capturing = cap_en_ff && !link.halted;
   assign enable_rise = wr && hit(avs_address, trw_pkg::OFF_CAPTURE_CONTROL) && !cap_en_ff
      && avs_writedata[trw_pkg::CAPTURE_ENABLE_BIT];

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cap_en_ff <= 1'b0;
      end else if (ce && wr && hit(avs_address, trw_pkg::OFF_CAPTURE_CONTROL)) begin
         cap_en_ff <= avs_writedata[trw_pkg::CAPTURE_ENABLE_BIT];
      end
   end

   // disable or count end asks formatter to stop
   assign link.stop_req = !cap_en_ff || done_ff;

   // ----------------------------------------------------------------
   // Trace RAM writes
   // ----------------------------------------------------------------
   // store formatter word
   assign hw_store = link.word_valid && !link.halted && !done_ff;
   // Software writes wait for halt so a draining word is never overwritten
   // software data word
   assign sw_store = wr && hit(avs_address, trw_pkg::OFF_WRITE_DATA) && !cap_en_ff && link.halted;
   assign store = hw_store || sw_store;
   assign store_data = hw_store ? link.word_data : avs_writedata;
   assign wrap = store && (wp_ff == {PTR_W{1'b1}});

   always_ff @(posedge ref_clk) begin
      if (ce && store) begin
         mem[wp_ff] <= store_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wp_ff <= trw_pkg::RST_POINTER;
      end else if (ce) begin
         if (store) begin
            wp_ff <= wp_ff + 1'b1;
         end else if (wr && hit(avs_address, trw_pkg::OFF_WRITE_POINTER) && !capturing) begin
            wp_ff <= avs_writedata[PTR_W-1:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         full_ff <= 1'b0;
      end else if (ce) begin
         if (wrap) begin
            full_ff <= 1'b1;
         end else if (wr && hit(avs_address, trw_pkg::OFF_WRITE_POINTER) && !capturing) begin
            full_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Post-trigger counter
   // ----------------------------------------------------------------
   // no update during capture
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         trg_ff <= trw_pkg::RST_TRIGGER_COUNT;
      end else if (ce && wr && hit(avs_address, trw_pkg::OFF_TRIGGER_COUNT) && !capturing) begin
         trg_ff <= avs_writedata[PTR_W-1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         armed_ff <= 1'b0;
         done_ff <= 1'b0;
         cnt_ff <= trw_pkg::RST_TRIGGER_COUNT;
      end else if (ce) begin
         if (enable_rise) begin
            armed_ff <= 1'b0;
            done_ff <= 1'b0;
         end else if (hw_store && !armed_ff && link.word_trigger) begin
            armed_ff <= 1'b1;
            cnt_ff <= trg_ff;
         end else if (hw_store && armed_ff) begin
            if (cnt_ff == '0) begin
               done_ff <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff - 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Read-back port
   // ----------------------------------------------------------------
   // Reading data steps the pointer; reads during capture see live RAM
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rp_ff <= trw_pkg::RST_POINTER;
      end else if (ce) begin
         if (rd && hit(avs_address, trw_pkg::OFF_READ_DATA)) begin
            rp_ff <= rp_ff + 1'b1;
         end else if (wr && hit(avs_address, trw_pkg::OFF_READ_POINTER) && !capturing) begin
            rp_ff <= avs_writedata[PTR_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   assign irq_ev[trw_pkg::IRQ_WRAP_BIT] = wrap;
   assign irq_ev[trw_pkg::IRQ_TRIG_DONE_BIT] = hw_store && armed_ff && (cnt_ff == '0);
   assign irq_ev[trw_pkg::IRQ_HALTED_BIT] = link.halted && !halted_d_ff;
   assign irq_clr = (wr && hit(avs_address, trw_pkg::OFF_IRQ_STATUS)) ? avs_writedata[2:0] : 3'h0;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         halted_d_ff <= 1'b1;
         ist_ff <= 3'h0;
      end else if (ce) begin
         halted_d_ff <= link.halted;
         // A new event outranks a clear in the same cycle
         ist_ff <= (ist_ff & ~irq_clr) | irq_ev;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         imask_ff <= trw_pkg::RST_IRQ_MASK;
      end else if (ce && wr && hit(avs_address, trw_pkg::OFF_IRQ_MASK)) begin
         imask_ff <= avs_writedata[2:0];
      end
   end

   assign irq = |(ist_ff & imask_ff);
endmodule
`default_nettype wire

// File: tb/trw_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module trw_link_assertions (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic word_valid,
   input wire logic [31:0] word_data,
   input wire logic word_trigger,
   input wire logic stop_req,
   input wire logic halted
);
   // ------------------------------------------------------------
   // Formatter stop handshake
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   a_stop_reaches_halt: assert property (stop_req && !halted |-> ##[1:2] halted)
      else $error("stop request did not halt the formatter");
   a_halt_holds_stopped: assert property (stop_req && halted |=> halted)
      else $error("formatter left halt while stop requested");
   a_run_holds_open: assert property (!stop_req && !halted |=> !halted)
      else $error("formatter halted without a stop request");
   a_halt_release_run: assert property (halted && !stop_req |=> !halted)
      else $error("formatter stayed halted after stop released");
   a_halt_no_words: assert property (halted |-> !word_valid)
      else $error("word offered while halted");
   a_trigger_with_word: assert property (word_trigger |-> word_valid)
      else $error("trigger flag without a word");
   a_halt_after_stop: assert property ($rose(halted) |-> $past(stop_req, 2))
      else $error("halt without earlier stop request");
   a_resume_needs_clear: assert property ($fell(halted) |-> !$past(stop_req))
      else $error("formatter resumed under a stop request");
   a_idle_data_stable: assert property (!word_valid |-> $stable(word_data))
      else $error("word data moved without a word");

   c_trigger_word: cover property (word_trigger && word_valid);
   c_halt_entry: cover property ($rose(halted));
   c_capture_start: cover property ($fell(halted));
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb;
   logic ref_clk, sys_rst, ce, avs_read, avs_write, avs_waitrequest, irq;
   logic in_valid, in_trigger, in_ready;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, in_data;
   int error_cnt = 0;
   int checks_done = 0;
   int i;

   trw_link_if lnk (.ref_clk(ref_clk));
   trw_formatter i_trw_formatter (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .link(lnk),
      .in_valid(in_valid), .in_data(in_data), .in_trigger(in_trigger), .in_ready(in_ready));
   trw_trace_dev i_trw_trace_dev (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .link(lnk),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq));
   trw_link_assertions i_trw_link_assertions (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .word_valid(lnk.word_valid), .word_data(lnk.word_data), .word_trigger(lnk.word_trigger),
      .stop_req(lnk.stop_req), .halted(lnk.halted));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // ------------------------------------------------------------
   // Bus and stream tasks
   // ------------------------------------------------------------
   task automatic bus(input logic [5:0] a, input logic is_wr, input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= is_wr;
      avs_read <= !is_wr;
      avs_writedata <= d;
      // Only the watchdog ends a wait that never gets its answer
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      bus(a, 1'b0, 32'h00000000, q);
      `CHK(nm, e, q)
   endtask

   // Holds the word until in_ready; in_ready is also high in halt, so a word offered then is dropped
   task automatic push(input logic [31:0] d, input logic t);
      @(posedge ref_clk);
      in_valid <= 1'b1;
      in_data <= d;
      in_trigger <= t;
      do begin
         @(posedge ref_clk);
      end while (in_ready !== 1'b1);
      in_valid <= 1'b0;
      in_trigger <= 1'b0;
   endtask

   task automatic wait_halt(input logic v);
      while (lnk.halted !== v) begin
         @(posedge ref_clk);
      end
   endtask

   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      ce = 1'b1;
      sys_rst = 1'b1;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      in_valid = 1'b0;
      in_data = 32'h00000000;
      in_trigger = 1'b0;
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd_chk(trw_pkg::OFF_WRITE_POINTER, 32'h00000000, "pointer reset");
      rd_chk(trw_pkg::OFF_TRIGGER_COUNT, 32'h00000000, "count reset");
      rd_chk(trw_pkg::OFF_FLUSH_STATUS, 32'h00000002, "status reset");
      rd_chk(trw_pkg::OFF_IRQ_STATUS, 32'h00000000, "no event after reset");
      rd_chk(6'h3C, 32'h00000000, "unmapped read");
      wr(trw_pkg::OFF_WRITE_POINTER, 32'hFFFFF3F0);
      rd_chk(trw_pkg::OFF_WRITE_POINTER, 32'h000003F0, "pointer load");
      wr(trw_pkg::OFF_TRIGGER_COUNT, 32'hFFFFF003);
      rd_chk(trw_pkg::OFF_TRIGGER_COUNT, 32'h00000003, "count load");
      for (i = 0; i < 4; i++) wr(trw_pkg::OFF_WRITE_DATA, 32'hA5A50000 + i);
      rd_chk(trw_pkg::OFF_WRITE_POINTER, 32'h000003F4, "pointer after data");
      wr(trw_pkg::OFF_CAPTURE_CONTROL, 32'h00000001);
      wait_halt(1'b0);
      wr(trw_pkg::OFF_WRITE_POINTER, 32'h00000000);
      wr(trw_pkg::OFF_TRIGGER_COUNT, 32'h00000005);
      wr(trw_pkg::OFF_WRITE_DATA, 32'h00000001);
      rd_chk(trw_pkg::OFF_WRITE_POINTER, 32'h000003F4, "pointer locked");
      rd_chk(trw_pkg::OFF_TRIGGER_COUNT, 32'h00000003, "count locked");
      // Twelve words carry the pointer from 0x3F4 past 0x3FF to zero
      for (i = 0; i < 12; i++) push(32'h00001000 + i, 1'b0);
      rd_chk(trw_pkg::OFF_WRITE_POINTER, 32'h00000000, "pointer wrapped");
      rd_chk(trw_pkg::OFF_FLUSH_STATUS, 32'h00000001, "full flag");
      rd_chk(trw_pkg::OFF_IRQ_STATUS, 32'h00000001, "wrap event");
      `CHK("irq masked", 1'b0, irq)
      wr(trw_pkg::OFF_IRQ_MASK, 32'h00000007);
      @(negedge ref_clk);
      `CHK("irq unmasked", 1'b1, irq)
      // Trigger word plus count+1 words land, the rest are discarded
      push(32'hC0DE0000, 1'b1);
      for (i = 0; i < 10; i++) push(32'h00002000 + i, 1'b0);
      wait_halt(1'b1);
      rd_chk(trw_pkg::OFF_WRITE_POINTER, 32'h00000005, "post trigger words");
      rd_chk(trw_pkg::OFF_FLUSH_STATUS, 32'h00000003, "halted flag");
      rd_chk(trw_pkg::OFF_IRQ_STATUS, 32'h00000007, "event status");
      wr(trw_pkg::OFF_IRQ_STATUS, 32'h00000007);
      @(negedge ref_clk);
      `CHK("irq cleared", 1'b0, irq)
      rd_chk(trw_pkg::OFF_IRQ_STATUS, 32'h00000000, "status cleared");
      wr(trw_pkg::OFF_CAPTURE_CONTROL, 32'h00000000);
      wr(trw_pkg::OFF_CAPTURE_CONTROL, 32'h00000001);
      wait_halt(1'b0);
      push(32'h00003000, 1'b0);
      push(32'h00003001, 1'b0);
      wr(trw_pkg::OFF_CAPTURE_CONTROL, 32'h00000000);
      wait_halt(1'b1);
      rd_chk(trw_pkg::OFF_WRITE_POINTER, 32'h00000007, "drain stored");
      wr(trw_pkg::OFF_WRITE_POINTER, 32'h00000100);
      rd_chk(trw_pkg::OFF_WRITE_POINTER, 32'h00000100, "pointer reload");
      rd_chk(trw_pkg::OFF_FLUSH_STATUS, 32'h00000002, "full cleared");
      // Read back what software and the formatter left in the RAM
      wr(trw_pkg::OFF_READ_POINTER, 32'h000003F3);
      rd_chk(trw_pkg::OFF_READ_DATA, 32'hA5A50003, "software word");
      rd_chk(trw_pkg::OFF_READ_DATA, 32'h00001000, "formatter word");
      wr(trw_pkg::OFF_READ_POINTER, 32'h00000000);
      rd_chk(trw_pkg::OFF_READ_DATA, 32'hC0DE0000, "trigger word");
      complete_run();
   end

   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge ref_clk);
      error_cnt++;
      complete_run();
   end
endmodule
`default_nettype wire
